// File: verilog/idp_identify.sv
// identify parameter block builder with avalon register slave
// ==========================================================
// Summary of operation
// - identify data leaves as 256 words over the read-sector data handshake
// - reserved bits and words of the block read as zero
// - word 0 gives the removable value in pc card mode, alternate in true ide
// - words 1, 3, 6 give default cylinders, heads, sectors; word 3 high byte zero
// - words 7 and 8 give total sectors, word 7 the high half
// - words 10 to 19 hold the ascii serial number right justified
// - words 54 to 56 give current cylinders, heads, sectors per track
// - words 57 and 58 hold the product of current geometry
// - word 57 is the low half of current capacity, word 58 the high
// - word 59 bits 15 to 9 zero, bit 8 one
// - word 59 low byte is the multiple count, only zero or one
// - words 60 and 61 give sectors addressable by lba
// - word 63 high byte one-hot selected dma mode 0 to 2 in true ide, rest zero
// - word 63 low byte flags supported dma modes 0 to 2 in true ide, zero in pc card mode
// - dma modes above 2 and pio above 4 appear only in word 163
// - word 64 flags pio modes 3 and 4, bits 7 to 2 zero
// - word 65 returns 50h as minimum dma cycle time
// - word 66 returns 50h as recommended dma cycle time
// - word 67 returns 50h as pio cycle time without flow control
// - word 68 returns 50h as pio cycle time with iordy
// - word 163 bits 2 to 0 return 2
// - word 163 bits 5 to 3 return 2
// - word 163 bits 8 to 6 and 11 to 9 show selected advanced modes
// - word 164 bits 2 to 0 return 3
// - word 164 bits 5 to 3 return 3
`timescale 1ns/1ps
module idp_identify
  import idp_pkg::*;
#(
  parameter logic [15:0] CFG_WORD_PCC = 16'h8c8c, // arbitrary value
  parameter logic [15:0] CFG_WORD_IDE = 16'h0c0c // arbitrary value
)(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cmd_identify,
  input wire logic mode_upd_valid,
  input wire idp_mode_s mode_upd,
  output idp_word_s out_word,
  output logic out_valid,
  input wire logic out_ready,
  output logic busy,
  output logic done
);

  // ==========================================================
  // declarations
  idp_state_e state_r;
  logic [7:0] idx_r;
  logic [15:0] def_cyl_r;
  logic [7:0] def_heads_r;
  logic [15:0] def_spt_r;
  logic [31:0] total_r;
  logic [15:0] cur_cyl_r;
  logic [7:0] cur_heads_r;
  logic [15:0] cur_spt_r;
  logic [31:0] lba_r;
  idp_mode_s mode_r;
  logic ide_mode_r;
  logic [4:0] ser_len_r;
  logic [7:0] ser_r [IDP_SERIAL_BYTES];
  logic [7:0] ser_field [IDP_SERIAL_BYTES];
  logic [4:0] pad_cnt;
  logic [31:0] cap;
  logic [31:0] rd_mux;
  logic [31:0] wr_val;
  logic wr_go;
  logic start;
  logic load;
  logic [15:0] word_nxt;

  // ==========================================================
  // avalon handshake
  // merge write data into the old value by byte lane
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  // one wait cycle, then a one-cycle grant
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
    end
  end

  assign wr_go = avs_write && !avs_waitrequest;
  assign wr_val = be_merge(rd_mux, avs_writedata, avs_byteenable);

  // read data captured in the wait cycle, stands through the grant
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_mux;
    end
  end

  // ==========================================================
  // register read mux, unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address >= OFS_SERIAL && avs_address < OFS_SERIAL_LEN) begin
      for (int b = 0; b < 4; b++) begin
        rd_mux[8*b +: 8] = ser_r[5'(avs_address - OFS_SERIAL) + 5'(b)];
      end
    end else begin
      unique case (avs_address)
        OFS_CTRL: rd_mux[CTRL_IDE_POS] = ide_mode_r;
        OFS_STATUS: begin
          rd_mux[STAT_BUSY_POS] = busy;
          rd_mux[STAT_IDX_POS +: 8] = idx_r;
        end
        OFS_DEF_GEOM: rd_mux = {8'h00, def_heads_r, def_cyl_r};
        OFS_DEF_SPT: rd_mux[15:0] = def_spt_r;
        OFS_TOTAL: rd_mux = total_r;
        OFS_CUR_GEOM: rd_mux = {8'h00, cur_heads_r, cur_cyl_r};
        OFS_CUR_SPT: rd_mux[15:0] = cur_spt_r;
        OFS_LBA: rd_mux = lba_r;
        OFS_MODE: begin
          rd_mux[MODE_MULT_POS] = mode_r.mult;
          rd_mux[MODE_MDMA_POS +: 2] = mode_r.mdma;
          rd_mux[MODE_PIO_POS +: 3] = mode_r.adv_pio;
          rd_mux[MODE_AMDMA_POS +: 3] = mode_r.adv_mdma;
        end
        OFS_SERIAL_LEN: rd_mux[4:0] = ser_len_r;
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // geometry and count registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      def_cyl_r <= GEOM_RST;
      def_heads_r <= 8'h00;
      def_spt_r <= GEOM_RST;
      total_r <= COUNT_RST;
    end else if (wr_go) begin
      if (avs_address == OFS_DEF_GEOM) begin
        def_cyl_r <= wr_val[15:0];
        def_heads_r <= wr_val[GEOM_HEADS_POS +: 8];
      end
      if (avs_address == OFS_DEF_SPT) begin
        def_spt_r <= wr_val[15:0];
      end
      if (avs_address == OFS_TOTAL) begin
        total_r <= wr_val;
      end
    end
  end

  // current translation registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cur_cyl_r <= GEOM_RST;
      cur_heads_r <= 8'h00;
      cur_spt_r <= GEOM_RST;
      lba_r <= COUNT_RST;
    end else if (wr_go) begin
      if (avs_address == OFS_CUR_GEOM) begin
        cur_cyl_r <= wr_val[15:0];
        cur_heads_r <= wr_val[GEOM_HEADS_POS +: 8];
      end
      if (avs_address == OFS_CUR_SPT) begin
        cur_spt_r <= wr_val[15:0];
      end
      if (avs_address == OFS_LBA) begin
        lba_r <= wr_val;
      end
    end
  end

  // interface mode and serial length, length clamped to the field
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ide_mode_r <= 1'b0;
      ser_len_r <= SERIAL_LEN_RST;
    end else if (wr_go) begin
      if (avs_address == OFS_CTRL) begin
        ide_mode_r <= wr_val[CTRL_IDE_POS];
      end
      if (avs_address == OFS_SERIAL_LEN) begin
        ser_len_r <= (wr_val[4:0] > 5'(IDP_SERIAL_BYTES)) ? 5'(IDP_SERIAL_BYTES) : wr_val[4:0];
      end
    end
  end

  // transfer mode settings, a host update from the command side wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_r <= '0;
    end else if (mode_upd_valid) begin
      mode_r <= mode_upd;
    end else if (wr_go && avs_address == OFS_MODE) begin
      mode_r.mult <= wr_val[MODE_MULT_POS];
      mode_r.mdma <= wr_val[MODE_MDMA_POS +: 2];
      mode_r.adv_pio <= wr_val[MODE_PIO_POS +: 3];
      mode_r.adv_mdma <= wr_val[MODE_AMDMA_POS +: 3];
    end
  end

  // ==========================================================
  // serial number store and right-justified field
  assign pad_cnt = 5'(IDP_SERIAL_BYTES) - ser_len_r;

  for (genvar k = 0; k < IDP_SERIAL_BYTES; k++) begin : g_ser
    // one byte lane of one serial register
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        ser_r[k] <= 8'h00;
      end else if (wr_go && avs_address == OFS_SERIAL + 8'(4 * (k / 4))) begin
        ser_r[k] <= wr_val[8 * (k % 4) +: 8];
      end
    end
    // characters shifted to the end of the field, padded in front
    assign ser_field[k] = (5'(k) >= pad_cnt) ? ser_r[5'(k) - pad_cnt] : SERIAL_PAD;
  end

  // ==========================================================
  // current capacity product
  idp_capacity u_cap (
    .sys_clk(sys_clk),
    .rst(rst),
    .cyl(cur_cyl_r),
    .heads(cur_heads_r),
    .spt(cur_spt_r),
    .cap(cap)
  );

  // ==========================================================
  // word builder, every word not listed reads zero
  always_comb begin
    word_nxt = 16'h0000;
    if (idx_r >= W_SERIAL_FIRST && idx_r <= W_SERIAL_LAST) begin
      word_nxt = {ser_field[5'({idx_r - W_SERIAL_FIRST, 1'b0})],
                  ser_field[5'({idx_r - W_SERIAL_FIRST, 1'b1})]};
    end else begin
      unique case (idx_r)
        W_CONFIG: word_nxt = ide_mode_r ? CFG_WORD_IDE : CFG_WORD_PCC;
        W_DEF_CYL: word_nxt = def_cyl_r;
        W_DEF_HEADS: word_nxt = {8'h00, def_heads_r};
        W_DEF_SPT: word_nxt = def_spt_r;
        W_TOTAL_MSW: word_nxt = total_r[31:16];
        W_TOTAL_LSW: word_nxt = total_r[15:0];
        W_VALIDITY: word_nxt = VALIDITY_VAL;
        W_CUR_CYL: word_nxt = cur_cyl_r;
        W_CUR_HEADS: word_nxt = {8'h00, cur_heads_r};
        W_CUR_SPT: word_nxt = cur_spt_r;
        W_CAP_LSW: word_nxt = cap[15:0];
        W_CAP_MSW: word_nxt = cap[31:16];
        W_MULT: word_nxt = MULT_VALID | {15'h0000, mode_r.mult};
        W_LBA_LSW: word_nxt = lba_r[15:0];
        W_LBA_MSW: word_nxt = lba_r[31:16];
        W_MDMA: begin
          // pc card mode reports no dma in this word
          if (ide_mode_r) begin
            word_nxt[7:0] = MDMA_SUPPORTED;
            if (mode_r.mdma != 2'h0) begin
              word_nxt[4'd8 + 4'(mode_r.mdma - 2'h1)] = 1'b1;
            end
          end
        end
        W_ADV_PIO: word_nxt = ADV_PIO_SUPPORTED;
        W_MDMA_MIN: word_nxt = CYCLE_NS;
        W_MDMA_REC: word_nxt = CYCLE_NS;
        W_PIO_MIN: word_nxt = CYCLE_NS;
        W_PIO_IORDY: word_nxt = CYCLE_NS;
        W_IDE_TIMING: word_nxt = {4'h0, mode_r.adv_mdma, mode_r.adv_pio,
                                  IDE_MDMA_MAX, IDE_PIO_MAX};
        W_PCC_TIMING: word_nxt = {10'h000, PCC_MEM_MAX, PCC_IO_MAX};
        default: word_nxt = 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // transfer sequencing
  assign start = cmd_identify || (wr_go && avs_address == OFS_CTRL && wr_val[CTRL_START_POS]);
  assign load = !out_valid || out_ready;

  // state and word counter; a start while busy is ignored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= IDP_IDLE;
      idx_r <= 8'h00;
    end else begin
      unique case (state_r)
        IDP_IDLE: begin
          if (start) begin
            state_r <= IDP_SEND;
            idx_r <= 8'h00;
          end
        end
        IDP_SEND: begin
          if (load) begin
            if (idx_r == IDP_LAST_IDX) begin
              state_r <= IDP_DRAIN;
            end else begin
              idx_r <= idx_r + 8'h01;
            end
          end
        end
        IDP_DRAIN: begin
          if (out_ready) begin
            state_r <= IDP_IDLE;
          end
        end
      endcase
    end
  end

  // data word output stage, held until the sink takes it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_word <= '0;
      out_valid <= 1'b0;
    end else if (state_r == IDP_SEND && load) begin
      out_word.data <= word_nxt;
      out_word.index <= idx_r;
      out_word.last <= (idx_r == IDP_LAST_IDX);
      out_valid <= 1'b1;
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  // busy level and end-of-block pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= (state_r == IDP_DRAIN) && out_ready;
      if (state_r == IDP_IDLE && start) begin
        busy <= 1'b1;
      end else if (state_r == IDP_DRAIN && out_ready) begin
        busy <= 1'b0;
      end
    end
  end

endmodule

// File: verilog/idp_pkg.sv
// constants, field layouts and carrier types of the identify parameter block
package idp_pkg;

  // ==========================================================
  // block geometry
  localparam int IDP_WORDS = 256;
  localparam logic [7:0] IDP_LAST_IDX = 8'hff;
  localparam int IDP_SERIAL_BYTES = 20;

  // ==========================================================
  // register byte offsets on the avalon slave
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DEF_GEOM = 8'h08;
  localparam logic [7:0] OFS_DEF_SPT = 8'h0c;
  localparam logic [7:0] OFS_TOTAL = 8'h10;
  localparam logic [7:0] OFS_CUR_GEOM = 8'h14;
  localparam logic [7:0] OFS_CUR_SPT = 8'h18;
  localparam logic [7:0] OFS_LBA = 8'h1c;
  localparam logic [7:0] OFS_MODE = 8'h20;
  localparam logic [7:0] OFS_SERIAL = 8'h24;
  localparam logic [7:0] OFS_SERIAL_LEN = 8'h38;

  // ==========================================================
  // register field positions
  localparam int CTRL_START_POS = 0;
  localparam int CTRL_IDE_POS = 1;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_IDX_POS = 8;
  localparam int GEOM_HEADS_POS = 16;
  localparam int MODE_MULT_POS = 0;
  localparam int MODE_MDMA_POS = 8;
  localparam int MODE_PIO_POS = 10;
  localparam int MODE_AMDMA_POS = 13;

  // ==========================================================
  // word numbers inside the parameter block
  localparam logic [7:0] W_CONFIG = 8'h00;
  localparam logic [7:0] W_DEF_CYL = 8'h01;
  localparam logic [7:0] W_DEF_HEADS = 8'h03;
  localparam logic [7:0] W_DEF_SPT = 8'h06;
  localparam logic [7:0] W_TOTAL_MSW = 8'h07;
  localparam logic [7:0] W_TOTAL_LSW = 8'h08;
  localparam logic [7:0] W_SERIAL_FIRST = 8'h0a;
  localparam logic [7:0] W_SERIAL_LAST = 8'h13;
  localparam logic [7:0] W_VALIDITY = 8'h35;
  localparam logic [7:0] W_CUR_CYL = 8'h36;
  localparam logic [7:0] W_CUR_HEADS = 8'h37;
  localparam logic [7:0] W_CUR_SPT = 8'h38;
  localparam logic [7:0] W_CAP_LSW = 8'h39;
  localparam logic [7:0] W_CAP_MSW = 8'h3a;
  localparam logic [7:0] W_MULT = 8'h3b;
  localparam logic [7:0] W_LBA_LSW = 8'h3c;
  localparam logic [7:0] W_LBA_MSW = 8'h3d;
  localparam logic [7:0] W_MDMA = 8'h3f;
  localparam logic [7:0] W_ADV_PIO = 8'h40;
  localparam logic [7:0] W_MDMA_MIN = 8'h41;
  localparam logic [7:0] W_MDMA_REC = 8'h42;
  localparam logic [7:0] W_PIO_MIN = 8'h43;
  localparam logic [7:0] W_PIO_IORDY = 8'h44;
  localparam logic [7:0] W_IDE_TIMING = 8'ha3;
  localparam logic [7:0] W_PCC_TIMING = 8'ha4;

  // ==========================================================
  // fixed word contents
  localparam logic [15:0] VALIDITY_VAL = 16'h0003;
  localparam logic [15:0] MULT_VALID = 16'h0100;
  localparam logic [7:0] MDMA_SUPPORTED = 8'h07;
  localparam logic [15:0] ADV_PIO_SUPPORTED = 16'h0003;
  localparam logic [15:0] CYCLE_NS = 16'h0050;
  localparam logic [2:0] IDE_PIO_MAX = 3'h2;
  localparam logic [2:0] IDE_MDMA_MAX = 3'h2;
  localparam logic [2:0] PCC_IO_MAX = 3'h3;
  localparam logic [2:0] PCC_MEM_MAX = 3'h3;
  localparam logic [7:0] SERIAL_PAD = 8'h20;

  // ==========================================================
  // reset values
  localparam logic [15:0] GEOM_RST = 16'h0000;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam logic [4:0] SERIAL_LEN_RST = 5'h00;

  // ==========================================================
  // carrier types
  typedef struct packed {
    logic mult;
    logic [1:0] mdma;
    logic [2:0] adv_pio;
    logic [2:0] adv_mdma;
  } idp_mode_s;

  typedef struct packed {
    logic [15:0] data;
    logic [7:0] index;
    logic last;
  } idp_word_s;

  typedef enum logic [1:0] {IDP_IDLE, IDP_SEND, IDP_DRAIN} idp_state_e;

endpackage

// File: verilog/idp_capacity.sv
// registered product of cylinders, heads and sectors per track
`timescale 1ns/1ps
module idp_capacity
  import idp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] cyl,
  input wire logic [7:0] heads,
  input wire logic [15:0] spt,
  output logic [31:0] cap
);

  logic [23:0] ch_r;
  logic [39:0] full;

  // first stage: cylinders times heads
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ch_r <= 24'h000000;
    end else begin
      ch_r <= 24'(cyl) * 24'(heads);
    end
  end

  // second stage: times sectors per track, kept to the double word
  assign full = 40'(ch_r) * 40'(spt);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cap <= COUNT_RST;
    end else begin
      cap <= full[31:0];
    end
  end

endmodule

// File: tb/idp_identify_sva.sv
// concurrent checks on the ports of the identify block builder
`timescale 1ns/1ps
module idp_identify_sva
  import idp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic cmd_identify,
  input wire idp_word_s out_word,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic busy,
  input wire logic done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // transfer steps
  sequence s_take;
    out_valid && out_ready;
  endsequence
  sequence s_take_last;
    out_valid && out_ready && out_word.last;
  endsequence
  sequence s_first_word;
    busy && out_valid && out_word.index == 8'h00;
  endsequence

  // ==========================================================
  // handshake and stream order
  a_avs_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("slave did not answer one cycle after request");
  // the state moves to sending at the start edge, the first word is registered one edge later
  a_start_first: assert property (cmd_identify && !busy |=> ##1 s_first_word)
    else $error("identify did not start with word 0");
  a_word_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
    else $error("word changed while stalled");
  a_word_next: assert property (s_take and !out_word.last |=>
    out_valid && out_word.index == $past(out_word.index) + 8'h01)
    else $error("word index did not advance by one");
  a_last_done: assert property (s_take_last |=> done && !busy && !out_valid)
    else $error("no completion after last word");
  a_last_index: assert property (out_valid && out_word.last |-> out_word.index == IDP_LAST_IDX)
    else $error("last flag on wrong word");

  // ==========================================================
  // fixed word contents
  a_heads_byte: assert property (out_valid && out_word.index == W_DEF_HEADS |-> out_word.data[15:8] == 8'h00)
    else $error("default heads high byte not zero");
  a_mult_word: assert property (out_valid && out_word.index == W_MULT |-> out_word.data[15:1] == 15'h0080)
    else $error("multiple sector word malformed");
  a_dma_word: assert property (out_valid && out_word.index == W_MDMA |->
    $onehot0(out_word.data[15:8]) && out_word.data[15:11] == 5'h00 && out_word.data[7:3] == 5'h00)
    else $error("dma mode word malformed");
  a_pio_word: assert property (out_valid && out_word.index == W_ADV_PIO |->
    out_word.data[15:2] == 14'h0000)
    else $error("advanced pio word reserved bits set");
  a_cycle_words: assert property (out_valid && out_word.index inside {[W_MDMA_MIN:W_PIO_IORDY]}
    |-> out_word.data == CYCLE_NS)
    else $error("cycle time word wrong");
  a_ide_timing: assert property (out_valid && out_word.index == W_IDE_TIMING |->
    out_word.data[15:12] == 4'h0 && out_word.data[5:0] == 6'h12)
    else $error("true ide timing word wrong");
  a_pcc_timing: assert property (out_valid && out_word.index == W_PCC_TIMING |->
    out_word.data == 16'h001b)
    else $error("pc card timing word wrong");
  a_reserved_tail: assert property (out_valid && out_word.index > W_PCC_TIMING |-> out_word.data == 16'h0000)
    else $error("reserved tail word not zero");
endmodule

bind idp_identify idp_identify_sva i_sva (.sys_clk(sys_clk), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .cmd_identify(cmd_identify),
  .out_word(out_word), .out_valid(out_valid), .out_ready(out_ready), .busy(busy), .done(done));

// File: tb/idp_host_model.sv
// host-side sink that collects identify words like single-sector read data
`timescale 1ns/1ps
module idp_host_model
  import idp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic paced,
  output logic out_ready
);
  logic [1:0] gap_r;

  // ==========================================================
  // free-running phase counter for paced collection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gap_r <= 2'h0;
    end else begin
      gap_r <= gap_r + 2'h1;
    end
  end

  // ready every cycle, or one cycle in four (100 ns, above the 80 ns minimum) when paced
  assign out_ready = !paced || gap_r == 2'h3;
endmodule

// File: tb/testbench.sv
// self-checking bench for the identify block builder
`timescale 1ns/1ps
module testbench
  import idp_pkg::*;
;
  localparam logic [15:0] CFG_P = 16'h9a01; // arbitrary value
  localparam logic [15:0] CFG_I = 16'h1b02; // arbitrary value
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic cmd_identify = 1'b0;
  logic mode_upd_valid = 1'b0;
  logic pace = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  idp_mode_s mode_upd = '0;
  idp_word_s out_word;
  logic [31:0] avs_readdata, rd, tot, lba, cap;
  logic avs_waitrequest, out_valid, out_ready, busy, done, ide;
  integer num_errors = 0;
  integer check_count = 0;
  integer seed = 55747;
  idp_word_s exq[$];
  idp_word_s ex;
  logic [15:0] dcyl, dspt, ccyl, cspt;
  logic [7:0] dhd, chd;
  logic [7:0] ser [20];
  logic [4:0] slen;
  idp_mode_s md;

  // clock at 40 MHz
  always #12.5 sys_clk = ~sys_clk;

  idp_identify #(.CFG_WORD_PCC(CFG_P), .CFG_WORD_IDE(CFG_I)) i_dut (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cmd_identify(cmd_identify), .mode_upd_valid(mode_upd_valid), .mode_upd(mode_upd), .out_word(out_word),
    .out_valid(out_valid), .out_ready(out_ready), .busy(busy), .done(done));

  idp_host_model i_host (.sys_clk(sys_clk), .rst(rst), .paced(pace), .out_ready(out_ready));

  // ==========================================================
  // compare and report
  task automatic chk_word(input idp_word_s g, input idp_word_s e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: word got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: value got %h expected %h", $time, g, e);
    end
  endtask

  task automatic close_out;
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================
  // avalon master: hold the request until waitrequest is sampled low
  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) num_errors++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    av(1'b1, a, d, rd);
  endtask

  // ==========================================================
  // random card set-up through the registers
  task automatic prog(input logic m_ide);
    ide = m_ide;
    {dhd, dcyl} = 24'($random(seed));
    {chd, ccyl} = 24'($random(seed));
    {dspt, cspt} = $random(seed);
    tot = $random(seed);
    lba = $random(seed);
    slen = 5'($unsigned($random(seed)) % 21);
    foreach (ser[k]) ser[k] = 8'h41 + 8'($unsigned($random(seed)) % 26);
    wr(OFS_CTRL, {30'h0, ide, 1'b0});
    wr(OFS_DEF_GEOM, {8'h0, dhd, dcyl});
    wr(OFS_DEF_SPT, {16'h0, dspt});
    wr(OFS_TOTAL, tot);
    wr(OFS_CUR_GEOM, {8'h0, chd, ccyl});
    wr(OFS_CUR_SPT, {16'h0, cspt});
    wr(OFS_LBA, lba);
    for (int k = 0; k < 5; k++) wr(OFS_SERIAL + 8'(4 * k), {ser[4*k+3], ser[4*k+2], ser[4*k+1], ser[4*k]});
    wr(OFS_SERIAL_LEN, {27'h0, slen});
    av(1'b0, OFS_DEF_GEOM, 32'h0, rd);
    chk_reg(rd, {8'h0, dhd, dcyl});
  endtask

  // host mode change by pulse or by register, dma selection forced to a code
  task automatic set_mode(input logic by_pulse, input logic [1:0] code);
    md = 9'($random(seed));
    md.mdma = code;
    if (by_pulse) begin
      mode_upd <= md;
      mode_upd_valid <= 1'b1;
      @(posedge sys_clk);
      mode_upd_valid <= 1'b0;
    end else begin
      wr(OFS_MODE, {16'h0, md.adv_mdma, md.adv_pio, md.mdma, 7'h0, md.mult});
    end
  endtask

  // note the expected block, start identify, retrigger while busy, await completion
  task automatic run_id(input logic by_cmd);
    logic [15:0] w [256];
    logic [7:0] f [20];
    int n = 0;
    cap = ccyl * chd * cspt;
    foreach (w[i]) w[i] = 16'h0;
    w[0] = ide ? CFG_I : CFG_P;
    w[1] = dcyl;
    w[3] = {8'h00, dhd};
    w[6] = dspt;
    w[7] = tot[31:16];
    w[8] = tot[15:0];
    for (int k = 0; k < 20; k++) f[k] = (k < 20 - slen) ? 8'h20 : ser[k - 20 + slen];
    for (int k = 0; k < 10; k++) w[10 + k] = {f[2*k], f[2*k+1]};
    w[53] = 16'h0003;
    w[54] = ccyl;
    w[55] = {8'h00, chd};
    w[56] = cspt;
    w[57] = cap[15:0];
    w[58] = cap[31:16];
    w[59] = {15'h0080, md.mult};
    w[60] = lba[15:0];
    w[61] = lba[31:16];
    if (ide) w[63] = {5'h0, md.mdma == 2'h3, md.mdma == 2'h2, md.mdma == 2'h1, 8'h07};
    w[64] = 16'h0003;
    for (int k = 65; k < 69; k++) w[k] = 16'h0050;
    w[163] = {4'h0, md.adv_mdma, md.adv_pio, 6'h12};
    w[164] = 16'h001b;
    for (int k = 0; k < 256; k++) exq.push_back({w[k], k[7:0], k == 255});
    if (by_cmd) begin
      @(posedge sys_clk);
      cmd_identify <= 1'b1;
      @(posedge sys_clk);
      cmd_identify <= 1'b0;
    end else begin
      wr(OFS_CTRL, {30'h0, ide, 1'b1});
    end
    repeat (5) @(posedge sys_clk);
    cmd_identify <= 1'b1;
    @(posedge sys_clk);
    cmd_identify <= 1'b0;
    while (done !== 1'b1 && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    chk_reg(exq.size(), 32'h0);
  endtask

  // ==========================================================
  // monitor: each accepted word against the oldest note
  always @(posedge sys_clk) begin
    if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
      ex = exq.size() ? exq.pop_front() : {25{1'bx}};
      chk_word(out_word, ex);
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    av(1'b0, 8'hfc, 32'h0, rd);
    chk_reg(rd, 32'h0);
    av(1'b0, OFS_STATUS, 32'h0, rd);
    chk_reg(rd, 32'h0);
    for (int i = 0; i < 5; i++) begin
      prog(i != 0);
      set_mode(i[0], i[1:0]);
      pace <= i[1];
      run_id(i[0]);
      $display("test %0d finished", i);
    end
    close_out;
  end

  // watchdog
  initial begin
    #(25 * 60000);
    num_errors++;
    close_out;
  end
endmodule
